// *** rtl/ptx_link_tx.sv ***
// top of the parallel-to-serial pixel link transmitter
// Notes on behaviour
// - capture all 28 bits each pixel period
// - edge select high rising, low falling
// - seven bit slots per pixel period
// - four data lanes plus forwarded clock
// - forwarded clock follows pixel clock frequency
// - shutdown stops clocking, outputs high impedance
// - shutdown low clears every register asynchronously
// - fixed slot to pixel bit lane map
// - forwarded clock high four slots, low three
// - data valid only after lock time
module ptx_link_tx
  import ptx_pkg::*;
#(
  parameter int LOCK_CYCLES = int'(ptx_pkg::LOCK_CYCLES_CALC)  // lock wait, shorten in simulation
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clock_en,
  input wire logic i_pixel_clock_in,
  input wire logic i_capture_edge_select,
  input wire logic i_shutdown_clear_n,
  input wire logic [ptx_pkg::WORD_W-1:0] i_pixel_bit,
  output logic [ptx_pkg::LANE_N-1:0] o_lane_pos,
  output logic [ptx_pkg::LANE_N-1:0] o_lane_neg,
  output logic o_lane_oe_n,
  output logic o_forwarded_clock_pos,
  output logic o_forwarded_clock_neg,
  output logic o_forwarded_clock_oe_n,
  output logic o_locked
);
  import ptx_pkg::*;

  // ----------------------------------------------------------------
  // shutdown release synchroniser
  // ----------------------------------------------------------------
  logic [1:0] active_sync;  // ones shifted in after release
  logic active;             // block may run

  // low pin clears at once; release is seen two edges later
  always_ff @(posedge i_clock or negedge i_shutdown_clear_n) begin
    if (!i_shutdown_clear_n) begin
      active_sync <= 2'h0;
    end else if (i_clock_en) begin
      active_sync <= {active_sync[0], 1'b1};
    end
  end
  assign active = active_sync[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pclk_sync;           // pixel clock, third stage for edges
  logic [1:0] sel_sync;            // edge select level
  logic [WORD_W-1:0] data_sync0;   // first data stage
  logic [WORD_W-1:0] data_sync1;   // second data stage
  logic [WORD_W-1:0] data_sync2;   // lines up with pclk_sync[2]
  logic [2:0] next_pclk_sync;
  logic [1:0] next_sel_sync;

  always_comb begin
    next_pclk_sync = {pclk_sync[1:0], i_pixel_clock_in};
    next_sel_sync = {sel_sync[0], i_capture_edge_select};
  end

  // data takes one stage more than the clock compare, so it holds the
  // sample taken just before the pixel clock edge
  always_ff @(posedge i_clock or negedge active) begin
    if (!active) begin
      pclk_sync <= 3'h0;
      sel_sync <= 2'h0;
      data_sync0 <= '0;
      data_sync1 <= '0;
      data_sync2 <= '0;
    end else if (!i_rst_n) begin
      pclk_sync <= 3'h0;
      sel_sync <= 2'h0;
      data_sync0 <= '0;
      data_sync1 <= '0;
      data_sync2 <= '0;
    end else if (i_clock_en) begin
      pclk_sync <= next_pclk_sync;
      sel_sync <= next_sel_sync;
      data_sync0 <= i_pixel_bit;
      data_sync1 <= data_sync0;
      data_sync2 <= data_sync1;
    end
  end

  // ----------------------------------------------------------------
  // capture edge
  // ----------------------------------------------------------------
  logic pclk_rise;  // rising edge of pixel clock seen
  logic pclk_fall;  // falling edge seen
  logic capture;    // chosen edge, one cycle

  // select is static by agreement, so no glitch guard on it
  always_comb begin
    pclk_rise = pclk_sync[1] & ~pclk_sync[2];
    pclk_fall = ~pclk_sync[1] & pclk_sync[2];
    capture = sel_sync[1] ? pclk_rise : pclk_fall;
  end

  // ----------------------------------------------------------------
  // period measure and slot timing
  // ----------------------------------------------------------------
  ptx_per_t cycle_cnt;        // cycles since last capture
  ptx_per_t period;           // last measured period
  logic [PER_W:0] slot_acc;   // fractional slot accumulator
  ptx_slot_t slot;            // current bit slot
  ptx_per_t next_cycle_cnt;
  ptx_per_t next_period;
  logic [PER_W:0] next_slot_acc;
  ptx_slot_t next_slot;
  logic [PER_W:0] acc_sum;    // accumulator plus one step

  // the system clock stands in for the 7x bit clock: each cycle adds
  // seven parts and a slot ends when a full period is collected; the
  // slot edges jitter by one cycle, which is the price of no PLL
  always_comb begin
    next_cycle_cnt = cycle_cnt;
    next_period = period;
    next_slot_acc = slot_acc;
    next_slot = slot;
    acc_sum = slot_acc + (PER_W+1)'(SLOT_N);
    if (capture) begin
      // new pixel period: slot zero lines up with the capture edge
      next_period = (cycle_cnt == '1) ? cycle_cnt : cycle_cnt + 1'b1;
      next_cycle_cnt = '0;
      next_slot_acc = '0;
      next_slot = '0;
    end else begin
      if (cycle_cnt != '1) begin
        next_cycle_cnt = cycle_cnt + 1'b1;
      end
      if (slot == SLOT_W'(SLOT_N - 1)) begin
        // last slot lasts until the next capture
        next_slot_acc = slot_acc;
      end else if (acc_sum >= {1'b0, period}) begin
        next_slot = slot + 1'b1;
        next_slot_acc = acc_sum - {1'b0, period};
      end else begin
        next_slot_acc = acc_sum;
      end
    end
  end

  always_ff @(posedge i_clock or negedge active) begin
    if (!active) begin
      cycle_cnt <= '0;
      period <= '0;
      slot_acc <= '0;
      slot <= '0;
    end else if (!i_rst_n) begin
      cycle_cnt <= '0;
      period <= '0;
      slot_acc <= '0;
      slot <= '0;
    end else if (i_clock_en) begin
      cycle_cnt <= next_cycle_cnt;
      period <= next_period;
      slot_acc <= next_slot_acc;
      slot <= next_slot;
    end
  end

  // ----------------------------------------------------------------
  // lock state
  // ----------------------------------------------------------------
  ptx_state_t state;            // link state
  ptx_state_t next_state;
  logic [LOCK_W-1:0] lock_cnt;  // cycles waited for lock
  logic [LOCK_W-1:0] next_lock_cnt;

  // data is held back until the lock time has run out
  always_comb begin
    next_state = state;
    next_lock_cnt = lock_cnt;
    unique case (state)
      ST_WAIT: begin
        if (capture) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (lock_cnt >= LOCK_W'(LOCK_CYCLES - 1)) begin
          next_state = ST_RUN;
        end else begin
          next_lock_cnt = lock_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        // illegal code: restart the lock wait
        next_state = ST_WAIT;
        next_lock_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge active) begin
    if (!active) begin
      state <= ST_WAIT;
      lock_cnt <= '0;
    end else if (!i_rst_n) begin
      state <= ST_WAIT;
      lock_cnt <= '0;
    end else if (i_clock_en) begin
      state <= next_state;
      lock_cnt <= next_lock_cnt;
    end
  end

  // ----------------------------------------------------------------
  // word holder and lane select
  // ----------------------------------------------------------------
  logic [LANE_N-1:0] lane_bits;  // bits of current slot

  ptx_shifter u_shifter (
    .i_clock(i_clock),
    .i_clear_n(active),
    .i_rst_n(i_rst_n),
    .i_clock_en(i_clock_en),
    .i_load(capture),
    .i_word(data_sync2),
    .i_slot(slot),
    .o_lane_bits(lane_bits)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic [LANE_N-1:0] lane_out;   // registered lane levels
  logic fwd_out;                 // registered forwarded clock
  logic [LANE_N-1:0] next_lane_out;
  logic next_fwd_out;

  // lanes and clock leave from one register stage, so they stay aligned
  always_comb begin
    next_lane_out = '0;
    next_fwd_out = 1'b0;
    if (state == ST_RUN) begin
      next_lane_out = lane_bits;
      next_fwd_out = (slot < SLOT_W'(FWD_HIGH_SLOTS));
    end
  end

  always_ff @(posedge i_clock or negedge active) begin
    if (!active) begin
      lane_out <= '0;
      fwd_out <= 1'b0;
    end else if (!i_rst_n) begin
      lane_out <= '0;
      fwd_out <= 1'b0;
    end else if (i_clock_en) begin
      lane_out <= next_lane_out;
      fwd_out <= next_fwd_out;
    end
  end

  // drivers are off whenever shutdown is low
  assign o_lane_pos = lane_out;
  assign o_lane_neg = ~lane_out;
  assign o_lane_oe_n = ~active;
  assign o_forwarded_clock_pos = fwd_out;
  assign o_forwarded_clock_neg = ~fwd_out;
  assign o_forwarded_clock_oe_n = ~active;
  assign o_locked = (state == ST_RUN);

endmodule : ptx_link_tx

// *** inc/ptx_pkg.sv ***
// package of constants, types and the lane map for the pixel link transmitter
package ptx_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int WORD_W = 28;          // parallel pixel word
  localparam int LANE_N = 4;           // serial data lanes
  localparam int SLOT_N = 7;           // bit slots per pixel period
  localparam int SLOT_W = 3;           // width of a slot index
  localparam int IDX_W = 5;            // width of a pixel bit index
  localparam int FWD_HIGH_SLOTS = 4;   // slots with forwarded clock high
  localparam int PER_W = 8;            // width of the pixel period count in system cycles
  localparam int LOCK_W = 20;          // lock wait counter width

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ = 125000000;  // system clock rate
  localparam longint LOCK_TIME_MS = 6;      // lock time after release
  // least time, so round up to whole cycles
  localparam longint LOCK_CYCLES_CALC = (LOCK_TIME_MS * CLOCK_HZ + 999) / 1000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [SLOT_W-1:0] ptx_slot_t;
  typedef logic [PER_W-1:0] ptx_per_t;

  // link state, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,   // active, no pixel clock edge seen yet
    ST_LOCK = 3'b010,   // edges seen, waiting out the lock time
    ST_RUN  = 3'b100    // lanes carry valid data
  } ptx_state_t;

  // ----------------------------------------------------------------
  // lane map: pixel bit index per lane for a slot, {lane3..lane0}
  // ----------------------------------------------------------------
  function automatic logic [LANE_N*IDX_W-1:0] ptx_slot_map(input ptx_slot_t slot);
    logic [LANE_N*IDX_W-1:0] m;
    m = '0;
    case (slot)
      3'h0: m = {5'h05, 5'h14, 5'h09, 5'h01};
      3'h1: m = {5'h1B, 5'h13, 5'h08, 5'h00};
      3'h2: m = {5'h17, 5'h1A, 5'h12, 5'h07};
      3'h3: m = {5'h11, 5'h19, 5'h0F, 5'h06};
      3'h4: m = {5'h10, 5'h18, 5'h0E, 5'h04};
      3'h5: m = {5'h0B, 5'h16, 5'h0D, 5'h03};
      3'h6: m = {5'h0A, 5'h15, 5'h0C, 5'h02};
      default: m = '0;
    endcase
    return m;
  endfunction : ptx_slot_map

endpackage : ptx_pkg

// *** rtl/ptx_shifter.sv ***
// word holding register and per-slot lane selector of the pixel link transmitter
module ptx_shifter
  import ptx_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_clear_n,
  input wire logic i_rst_n,
  input wire logic i_clock_en,
  input wire logic i_load,
  input wire logic [ptx_pkg::WORD_W-1:0] i_word,
  input wire ptx_pkg::ptx_slot_t i_slot,
  output logic [ptx_pkg::LANE_N-1:0] o_lane_bits
);
  import ptx_pkg::*;

  // ----------------------------------------------------------------
  // held word
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word;       // word being shifted out
  logic [WORD_W-1:0] next_word;  // value at next edge

  // replace only at a pixel period boundary, so a word is never torn
  always_comb begin
    next_word = word;
    if (i_load) begin
      next_word = i_word;
    end
  end

  // shutdown clears at once, without waiting for the clock
  always_ff @(posedge i_clock or negedge i_clear_n) begin
    if (!i_clear_n) begin
      word <= '0;
    end else if (!i_rst_n) begin
      word <= '0;
    end else if (i_clock_en) begin
      word <= next_word;
    end
  end

  // ----------------------------------------------------------------
  // slice select
  // ----------------------------------------------------------------
  // each lane picks the pixel bit that the map gives for this slot
  always_comb begin
    logic [LANE_N*IDX_W-1:0] map;
    map = ptx_slot_map(i_slot);
    for (int l = 0; l < LANE_N; l++) begin
      o_lane_bits[l] = word[map[l*IDX_W +: IDX_W]];
    end
  end

endmodule : ptx_shifter

// *** tb/ptx_link_tx_sva.sv ***
// assertion checker for the pixel link transmitter
module ptx_link_tx_sva
  import ptx_pkg::*;
#(
  parameter int LOCK_CYCLES = 20
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_shutdown_clear_n,
  input wire logic [ptx_pkg::LANE_N-1:0] o_lane_pos,
  input wire logic [ptx_pkg::LANE_N-1:0] o_lane_neg,
  input wire logic o_lane_oe_n,
  input wire logic o_forwarded_clock_pos,
  input wire logic o_forwarded_clock_neg,
  input wire logic o_forwarded_clock_oe_n,
  input wire logic o_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  // cycles since shutdown release, saturating so it never wraps
  int age;
  int next_age;
  always_comb begin
    next_age = (age < 1000) ? age + 1 : age;
    if (!i_rst_n || !i_shutdown_clear_n) next_age = 0;
  end
  always_ff @(posedge i_clock) begin
    age <= next_age;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n || !i_shutdown_clear_n);

  // shutdown checks must stay live while shutdown is low; only reset masks
  // them, since the flops hold no value before the first clock edge
  property p_off_hiz;
    disable iff (!i_rst_n) !i_shutdown_clear_n |-> o_lane_oe_n && o_forwarded_clock_oe_n;
  endproperty
  property p_clear;
    disable iff (!i_rst_n) !i_shutdown_clear_n |-> o_lane_pos == 4'h0 && !o_forwarded_clock_pos && !o_locked;
  endproperty
  property p_on;
    $rose(i_shutdown_clear_n) |-> ##[1:3] !o_lane_oe_n;
  endproperty
  property p_lane_neg;
    o_locked |-> o_lane_neg == ~o_lane_pos;
  endproperty
  property p_fwd_neg;
    o_locked |-> o_forwarded_clock_neg == !o_forwarded_clock_pos;
  endproperty
  // the bench pixel period is eight cycles: slots 0..3 fill five of them,
  // slots 4..6 three; a rise right after lock may start mid-period, so skip it
  property p_fwd_duty;
    $rose(o_forwarded_clock_pos) && $past(o_locked, 2) |->
      o_forwarded_clock_pos [*5] ##1 !o_forwarded_clock_pos;
  endproperty
  property p_fwd_period;
    $rose(o_forwarded_clock_pos) && $past(o_locked, 2) |->
      ##1 (!$rose(o_forwarded_clock_pos)) [*7] ##1 $rose(o_forwarded_clock_pos);
  endproperty
  property p_idle_low;
    !o_locked |-> o_lane_pos == 4'h0 && !o_forwarded_clock_pos;
  endproperty
  property p_lock_time;
    $rose(o_locked) |-> age >= LOCK_CYCLES;
  endproperty

  a_off_hiz: assert property (p_off_hiz) else $error("lanes driven in shutdown");
  a_clear: assert property (p_clear) else $error("state not cleared in shutdown");
  a_on: assert property (p_on) else $error("lanes not enabled after release");
  a_lane_neg: assert property (p_lane_neg) else $error("lane pair not complementary");
  a_fwd_neg: assert property (p_fwd_neg) else $error("clock pair not complementary");
  a_fwd_duty: assert property (p_fwd_duty) else $error("forwarded clock high time wrong");
  a_fwd_period: assert property (p_fwd_period) else $error("forwarded clock period wrong");
  a_idle_low: assert property (p_idle_low) else $error("output active before lock");
  a_lock_time: assert property (p_lock_time) else $error("lock came too early");

  c_lock: cover property ($rose(o_locked));
  c_fwd: cover property ($rose(o_forwarded_clock_pos));
  c_stop: cover property (disable iff (1'b0) o_locked ##1 !i_shutdown_clear_n);
endmodule : ptx_link_tx_sva

bind ptx_link_tx ptx_link_tx_sva #(.LOCK_CYCLES(LOCK_CYCLES)) i_sva (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_shutdown_clear_n(i_shutdown_clear_n),
  .o_lane_pos(o_lane_pos), .o_lane_neg(o_lane_neg), .o_lane_oe_n(o_lane_oe_n),
  .o_forwarded_clock_pos(o_forwarded_clock_pos), .o_forwarded_clock_neg(o_forwarded_clock_neg),
  .o_forwarded_clock_oe_n(o_forwarded_clock_oe_n), .o_locked(o_locked));

// *** tb/ptx_rx_model.sv ***
// display-side receiver model that rebuilds pixel words from the lanes
module ptx_rx_model
  import ptx_pkg::*;
(
  input wire logic i_clock,
  input wire logic [ptx_pkg::LANE_N-1:0] i_lane_pos,
  input wire logic i_forwarded_clock_pos,
  input wire logic i_oe_n,
  output logic [ptx_pkg::WORD_W-1:0] o_word,
  output logic o_word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // pixel bit on lane l in slot s sits at s*4+l
  localparam int slot_bit [28] = '{1, 9, 20, 5, 0, 8, 19, 27, 7, 18, 26, 23, 6, 15, 25, 17,
                                   4, 14, 24, 16, 3, 13, 22, 11, 2, 12, 21, 10};
  logic [ptx_pkg::WORD_W-1:0] word = '0;
  logic fwd_prev = 1'b0;
  int slot = 7;
  initial o_word_valid = 1'b0;
  // slot 0 starts at the forwarded clock rise; each bit is read in the last
  // system cycle of its bit time, so with eight cycles to seven bits the
  // cycle of the rise itself is skipped and slot 6 is read once
  always @(posedge i_clock) begin
    o_word_valid <= 1'b0;
    if (i_forwarded_clock_pos && !fwd_prev && !i_oe_n) slot = -1;
    if (slot >= 0 && slot < 7) begin
      for (int l = 0; l < 4; l++) word[slot_bit[slot*4+l]] = i_lane_pos[l];
      if (slot == 6) begin
        o_word <= word;
        o_word_valid <= 1'b1;
      end
    end
    if (slot < 7) slot++;
    fwd_prev <= i_forwarded_clock_pos;
  end
endmodule : ptx_rx_model

// *** tb/ptx_link_tx_tb_top.sv ***
// testbench for the pixel link transmitter
module ptx_link_tx_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ptx_pkg::*;
  localparam int LOCK = 20;  // short lock wait for simulation
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic pix = 1'b0;
  logic sel = 1'b1;
  logic shut_n = 1'b0;  // held low until the pixel clock runs
  logic [WORD_W-1:0] data = '0;
  logic [LANE_N-1:0] lp;
  logic oe_n, fp, locked, rx_v;
  logic [WORD_W-1:0] rx_w;
  logic [WORD_W-1:0] got [$];
  int miscompares = 0;
  int num_checks = 0;

  initial begin
    forever #4 i_clock = ~i_clock;
  end
  // pixel clock: 64 ns, even duty, edges 1 ns after a system clock rise like all stimulus
  initial begin
    #5;
    forever #32 pix = ~pix;
  end

  ptx_link_tx #(.LOCK_CYCLES(LOCK)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clock_en(1'b1),
    .i_pixel_clock_in(pix), .i_capture_edge_select(sel), .i_shutdown_clear_n(shut_n), .i_pixel_bit(data),
    .o_lane_pos(lp), .o_lane_neg(), .o_lane_oe_n(oe_n), .o_forwarded_clock_pos(fp),
    .o_forwarded_clock_neg(), .o_forwarded_clock_oe_n(), .o_locked(locked));
  ptx_rx_model i_rx (.i_clock(i_clock), .i_lane_pos(lp), .i_forwarded_clock_pos(fp), .i_oe_n(oe_n),
    .o_word(rx_w), .o_word_valid(rx_v));

  always @(posedge i_clock) begin
    if (rx_v === 1'b1) got.push_back(rx_w);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // release shutdown and wait out the lock time
  task automatic t_lock();
    int n = 0;
    shut_n = 1'b1;
    while (locked !== 1'b1 && n < 400) begin
      check("outputs before lock", 0, {fp, lp});
      cyc(1);
      n++;
    end
    check("locked", 1, locked);
    check("lock wait", 1, n >= LOCK);
    check("lane oe_n", 0, oe_n);
    $display("lock test done");
  endtask : t_lock

  // back-to-back words, each changed one cycle after the edge opposite to capture
  task automatic t_stream();
    logic [WORD_W-1:0] sent [28];
    int k;
    int n;
    got.delete();
    wait (pix !== sel);
    wait (pix === sel);
    n = 0;
    // the clock is still high from the last word here; let it fall first
    while (fp === 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    while (fp !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    check("clock rise after capture edge", 1, n >= 3 && n <= 6);
    for (int i = 0; i < 28; i++) begin
      sent[i] = (i % 2) ? ~(28'h1 << i) : (28'h1 << i);
      wait (pix === sel);
      wait (pix !== sel);
      cyc(1);
      data = sent[i];
    end
    cyc(40);
    k = -1;
    foreach (got[j]) if (k < 0 && got[j] === sent[0]) k = j;
    check("first word found", 1, k >= 0);
    for (int i = 0; i < 28 && k >= 0; i++) begin
      check("word", sent[i], (k + i < got.size()) ? got[k+i] : 'x);
    end
    $display("stream test done, capture edge select %b", sel);
  endtask : t_stream

  // shutdown mid-stream: lanes released and state cleared at once
  task automatic t_shutdown();
    shut_n = 1'b0;
    #1;
    check("lane oe_n", 1, oe_n);
    check("outputs cleared", 0, {locked, fp, lp});
    cyc(10);
    check("clock stopped", 0, fp);
    $display("shutdown test done");
  endtask : t_shutdown

  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    cyc(16);
    i_rst_n = 1'b1;
    cyc(2);
    t_lock();
    t_stream();
    t_shutdown();
    sel = 1'b0;  // changed only while shut down
    cyc(2);
    t_lock();
    t_stream();
    test_done();
  end

  // watchdog: the run needs about 5 us
  initial begin
    #100us;
    miscompares++;
    $display("watchdog expired");
    test_done();
  end
endmodule : ptx_link_tx_tb_top
